// ---- ifsd_core.sv ----
/*
  Sixteen-channel input conditioning: pulse stretching, flutter
  monitoring, value status, diagnostics, interrupts, identification data.
  Assumes inputs synchronous to core_clk and a classic Wishbone master.
*/
// The address map and register access over Wishbone were chosen for this implementation.
// Overview of operation
// - group diagnostics off: no LED, no diag entry, value status still invalid
// - one window per channel, started by first monitored transition
// - flutter when transitions inside window exceed the limit
// - window ends quietly, channel idles until next transition
// - flutter copies input to image, invalid status, diag entry, incoming irq
// - clear after three quiet windows: drop diag, outgoing irq, valid
// - incoming and outgoing interrupts reported with diagnostic entries
// - stretcher lengthens short pulses, passes long pulses unchanged
// - monitor uses stretcher output when stretching is configured
// - sensor type is set for a whole channel pair
// - changeover pair: one type code stored per pair, no open/closed inversion
// - writable date 16, tag 32, description 32 characters
// - firmware bump also bumps hardware revision, both read only
// - stretch minimum off, 0.5 s, 1 s, 2 s; default off
// - window 0.5 s or 1..100 s; default 2 s
// - transition limit 2..31; default 5
`default_nettype none
module ifsd_core
#(
  parameter int unsigned TICK_CYCLES = ifsd_pkg::TICK_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] sensorIn,
  output logic [15:0]      processImage,
  output logic [15:0]      valueValid,
  output logic [15:0]      chanErrLed,
  output logic             irq
);
  typedef enum logic [1:0] {MON_IDLE, MON_WIN, MON_FLUT} ifsd_mon_e;

  ifsd_pkg::ifsd_wbreq_s req;
  ifsd_pkg::ifsd_chcfg_s cfg_r [16];
  ifsd_mon_e  st_r [16];
  logic [9:0]  winCnt_r [16]; // quiet span reaches 3 x 200 ticks
  logic [4:0]  trn_r [16];
  logic [15:0] mon_r;
  logic [15:0] gdiag_r;
  logic [6:0]  win_r;
  logic [2:0]  stype_r [8];
  logic [3:0]  chsel_r;
  logic        diagIrqEn_r;
  logic [15:0] flut_r;
  logic [31:0] irqSt_r;
  logic [31:0] irqEn_r;
  logic [31:0] hwRev_r;
  logic [31:0] fwRev_r;
  logic [31:0] statRev_r;
  logic [31:0] idRd;
  logic [25:0] tickCnt_r;
  logic        tick;
  logic        ack_r;
  logic [15:0] monIn;
  logic [15:0] evIn;
  logic [15:0] evOut;
  logic [7:0]  winTicks;
  logic        wr;
  logic        pend_r;
  logic        cfgWr;
  logic        idHit;
  logic [4:0]  idIdx;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction
  function automatic int unsigned QUIET_TICKS(input logic [7:0] w);
    return ifsd_pkg::QUIET_MULT * w;
  endfunction

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
  assign wr    = req.cyc && req.stb && req.we && !ack_r && !pend_r;
  assign idHit = req.adr >= ifsd_pkg::A_ID_BASE &&
                 req.adr < ifsd_pkg::A_ID_BASE +
                 8'(4 * ifsd_pkg::ID_WORDS);
  assign idIdx = 5'((req.adr - ifsd_pkg::A_ID_BASE) >> 2);
  assign cfgWr = wr && (hit(req.adr, ifsd_pkg::A_CTRL) ||
                 hit(req.adr, ifsd_pkg::A_GDIAG) ||
                 hit(req.adr, ifsd_pkg::A_FLEN) ||
                 hit(req.adr, ifsd_pkg::A_WIN) ||
                 hit(req.adr, ifsd_pkg::A_STYPE) ||
                 hit(req.adr, ifsd_pkg::A_CHCFG));

  // 0.5 s timebase shared by all channels
  always_ff @(posedge core_clk)
  begin
    if (rst || tickCnt_r == 26'(TICK_CYCLES - 1))
      tickCnt_r <= '0;
    else
      tickCnt_r <= tickCnt_r + 26'h1;
  end
  assign tick = (tickCnt_r == 26'(TICK_CYCLES - 1));

  // window length in half-second ticks
  assign winTicks = (win_r == 7'h00) ? 8'h01 : {win_r, 1'b0};

  for (genvar g = 0; g < 16; g++)
  begin : g_ch
    ifsd_stretch u_str
    (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick),
      .sel      (cfg_r[g].stretch),
      .din      (sensorIn[g]),
      .dout     (monIn[g])
    );
  end

  // flutter monitors
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mon_r <= '0;
      for (int c = 0; c < 16; c++)
      begin
        st_r[c]     <= MON_IDLE;
        winCnt_r[c] <= '0;
        trn_r[c]    <= '0;
      end
    end
    else
    begin
      mon_r <= monIn;
      for (int c = 0; c < 16; c++)
      begin
        unique case (st_r[c])
          MON_IDLE:
            if (cfg_r[c].flutEn && (monIn[c] ^ mon_r[c]))
            begin
              st_r[c]     <= MON_WIN;
              winCnt_r[c] <= {2'h0, winTicks};
              trn_r[c]    <= 5'h1;
            end
          MON_WIN:
            if (!cfg_r[c].flutEn)
              st_r[c] <= MON_IDLE;
            else if ((monIn[c] ^ mon_r[c]) && trn_r[c] >= cfg_r[c].limit)
            begin
              st_r[c]     <= MON_FLUT;
              winCnt_r[c] <= 10'(QUIET_TICKS(winTicks));
            end
            else if (tick && winCnt_r[c] == 10'h001)
            begin
              st_r[c]  <= MON_IDLE;
              trn_r[c] <= '0;
            end
            else
            begin
              if (tick)
                winCnt_r[c] <= winCnt_r[c] - 10'h001;
              if (monIn[c] ^ mon_r[c])
                trn_r[c] <= trn_r[c] + 5'h1;
            end
          MON_FLUT:
            if (monIn[c] ^ mon_r[c])
              winCnt_r[c] <= 10'(QUIET_TICKS(winTicks));
            else if (!cfg_r[c].flutEn || (tick && winCnt_r[c] == 10'h001))
            begin
              st_r[c]  <= MON_IDLE;
              trn_r[c] <= '0;
            end
            else if (tick)
              winCnt_r[c] <= winCnt_r[c] - 10'h001;
        endcase
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < 16; c++)
    begin
      flut_r[c] = (st_r[c] == MON_FLUT);
      evIn[c]   = st_r[c] == MON_WIN && cfg_r[c].flutEn &&
                  (monIn[c] ^ mon_r[c]) && trn_r[c] >= cfg_r[c].limit;
      evOut[c]  = st_r[c] == MON_FLUT && !(monIn[c] ^ mon_r[c]) &&
                  (!cfg_r[c].flutEn || (tick && winCnt_r[c] == 10'h001));
    end
  end

  // process image: frozen to the input at flutter, live otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst)
      processImage <= '0;
    else
      for (int c = 0; c < 16; c++)
        if (evIn[c] || !flut_r[c])
          processImage[c] <= monIn[c];
  end

  // value status invalid regardless of group diagnostics
  always_ff @(posedge core_clk)
  begin
    if (rst)
      valueValid <= '1;
    else
      valueValid <= ~((flut_r | evIn) & ~evOut);
  end

  // LED and diag entry only when group diagnostics enabled
  always_ff @(posedge core_clk)
  begin
    if (rst)
      chanErrLed <= '0;
    else
      chanErrLed <= (flut_r | evIn) & ~evOut & gdiag_r;
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irqSt_r <= '0;
    else
    begin
      logic [31:0] clr;
      clr = (wr && hit(req.adr, ifsd_pkg::A_IRQCLR)) ? req.dat : '0;
      irqSt_r <= (irqSt_r & ~clr) |
                 {evOut & gdiag_r, evIn & gdiag_r};
    end
  end
  assign irq = diagIrqEn_r && |(irqSt_r & irqEn_r);

  // configuration registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      gdiag_r     <= ifsd_pkg::GDIAG_RST;
      win_r       <= ifsd_pkg::WIN_RST;
      chsel_r     <= '0;
      diagIrqEn_r <= 1'b0;
      irqEn_r     <= '0;
      for (int c = 0; c < 16; c++)
        cfg_r[c] <= '{stretch: ifsd_pkg::STR_RST,
                      limit: ifsd_pkg::LIM_RST, flutEn: 1'b0};
      for (int k = 0; k < 8; k++)
        stype_r[k] <= ifsd_pkg::STYPE_RST;
    end
    else if (wr)
    begin
      if (hit(req.adr, ifsd_pkg::A_CTRL))
        diagIrqEn_r <= req.dat[0];
      if (hit(req.adr, ifsd_pkg::A_GDIAG))
        gdiag_r <= req.dat[15:0];
      if (hit(req.adr, ifsd_pkg::A_FLEN))
        for (int c = 0; c < 16; c++)
          cfg_r[c].flutEn <= req.dat[c];
      if (hit(req.adr, ifsd_pkg::A_WIN) && req.dat[6:0] <= ifsd_pkg::WIN_MAX)
        win_r <= req.dat[6:0];
      // type given for channel chsel lands on its pair
      if (hit(req.adr, ifsd_pkg::A_STYPE))
        stype_r[chsel_r[3:1]] <= req.dat[2:0];
      if (hit(req.adr, ifsd_pkg::A_CHSEL))
        chsel_r <= req.dat[3:0];
      if (hit(req.adr, ifsd_pkg::A_CHCFG))
      begin
        cfg_r[chsel_r].stretch <= req.dat[1:0];
        if (req.dat[6:2] >= ifsd_pkg::LIM_MIN)
          cfg_r[chsel_r].limit <= req.dat[6:2];
      end
      if (hit(req.adr, ifsd_pkg::A_IRQEN))
        irqEn_r <= req.dat;
    end
  end

  // revision counters, read only from the bus
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hwRev_r   <= ifsd_pkg::HW_REV_RST;
      fwRev_r   <= ifsd_pkg::FW_REV_RST;
      statRev_r <= '0;
    end
    else
    begin
      if (cfgWr)
        statRev_r <= statRev_r + 32'h1;
      if (wr && hit(req.adr, ifsd_pkg::A_FWBUMP))
      begin
        fwRev_r <= fwRev_r + 32'h1;
        hwRev_r <= hwRev_r + 32'h1;
      end
    end
  end

  ifsd_id_mem u_id
  (
    .core_clk (core_clk),
    .wrEn     (wr && idHit),
    .wrSel    (req.sel),
    .addr     (idIdx),
    .wrData   (req.dat),
    .rdData   (idRd)
  );

  // two-cycle answer so the id read lands; writes act in the first only
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
      ack_r  <= 1'b0;
    end
    else
    begin
      pend_r <= req.cyc && req.stb && !ack_r && !pend_r;
      ack_r  <= pend_r;
    end
  end
  assign wb_ack_o = ack_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wb_dat_o <= '0;
    else if (pend_r)
    begin
      if (idHit)
        wb_dat_o <= idRd;
      else
        unique case (req.adr)
          ifsd_pkg::A_CTRL:    wb_dat_o <= {31'h0, diagIrqEn_r};
          ifsd_pkg::A_GDIAG:   wb_dat_o <= {16'h0, gdiag_r};
          ifsd_pkg::A_WIN:     wb_dat_o <= {25'h0, win_r};
          ifsd_pkg::A_STYPE:   wb_dat_o <= {29'h0, stype_r[chsel_r[3:1]]};
          ifsd_pkg::A_CHSEL:   wb_dat_o <= {28'h0, chsel_r};
          ifsd_pkg::A_CHCFG:   wb_dat_o <= {25'h0, cfg_r[chsel_r].limit,
                                            cfg_r[chsel_r].stretch};
          ifsd_pkg::A_IMAGE:   wb_dat_o <= {16'h0, processImage};
          ifsd_pkg::A_VSTAT:   wb_dat_o <= {16'h0, valueValid};
          ifsd_pkg::A_DIAG:    wb_dat_o <= {16'h0, flut_r & gdiag_r};
          ifsd_pkg::A_IRQST:   wb_dat_o <= irqSt_r;
          ifsd_pkg::A_IRQEN:   wb_dat_o <= irqEn_r;
          ifsd_pkg::A_LED:     wb_dat_o <= {16'h0, chanErrLed};
          ifsd_pkg::A_MAKER:   wb_dat_o <= ifsd_pkg::MAKER_ID;
          ifsd_pkg::A_DEVID:   wb_dat_o <= ifsd_pkg::DEVICE_ID;
          ifsd_pkg::A_SERIAL:  wb_dat_o <= ifsd_pkg::SERIAL_RST;
          ifsd_pkg::A_HWREV:   wb_dat_o <= hwRev_r;
          ifsd_pkg::A_FWREV:   wb_dat_o <= fwRev_r;
          ifsd_pkg::A_STATREV: wb_dat_o <= statRev_r;
          default:             wb_dat_o <= '0;
        endcase
    end
  end
endmodule // ifsd_core
`default_nettype wire

// ---- ifsd_core_chk.sv ----
/*
  Port checker for ifsd_core: bus timing, reset state, value status.
  Assumes one clock domain and a master holding requests until ack.
*/
`default_nettype none
module ifsd_core_chk
#(
  parameter int unsigned TICK_CYCLES = 20
)
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] sensorIn,
  input wire logic [15:0] processImage,
  input wire logic [15:0] valueValid,
  input wire logic [15:0] chanErrLed,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence reqSeen;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence ackLate;
    ##2 wb_ack_o;
  endsequence
  ack_delay_a: assert property (reqSeen |-> ackLate)
    else $error("ack not two cycles after request");
  ack_gap_a: assert property (wb_ack_o |=> !wb_ack_o [*3])
    else $error("ack repeated too soon");
  ack_hold_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
    else $error("ack without a held request");
  ack_in_cycle_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack outside a bus cycle");
  reset_state_a: assert property ($fell(rst) |-> valueValid == 16'hFFFF &&
    chanErrLed == 16'h0000 && processImage == 16'h0000 && !irq)
    else $error("outputs not at reset values");
  led_invalid_a: assert property ((chanErrLed & valueValid) == 16'h0000)
    else $error("error led lit on a valid channel");
  image_freeze_a: assert property (((~$past(valueValid)) & ~valueValid &
    (processImage ^ $past(processImage))) == 16'h0000)
    else $error("image moved while channel invalid");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // ifsd_core_chk
`default_nettype wire

// ---- ifsd_core_tb.sv ----
/*
  Self-checking bench for ifsd_core with a short tick.
  Assumes the checker and sensor model files are compiled first.
*/
`default_nettype none
module ifsd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICKS = 20;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        wbCyc    = 1'b0;
  logic        wbStb    = 1'b0;
  logic        wbWe     = 1'b0;
  logic [3:0]  wbSel    = 4'h0;
  logic [7:0]  wbAdr    = 8'h00;
  logic [31:0] wbDatW   = 32'h0;
  logic [31:0] wbDatR, rdq;
  logic        wbAck, irq;
  logic [15:0] flipReq  = 16'h0;
  logic [15:0] sensorIn, processImage, valueValid, chanErrLed;
  int          err_total = 0;
  int          num_checks = 0;
  always #10 core_clk = ~core_clk;
  ifsd_core #(.TICK_CYCLES(TICKS)) DUT (.core_clk(core_clk), .rst(rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_sel_i(wbSel),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .sensorIn(sensorIn), .processImage(processImage),
    .valueValid(valueValid), .chanErrLed(chanErrLed), .irq(irq));
  ifsd_sensor_model SENS (.core_clk(core_clk), .rst(rst),
    .flipReq(flipReq), .sensorIn(sensorIn));
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= s;
    wbAdr <= a;
    wbDatW <= d;
    // no local limit: a hung wait is ended by the watchdog
    do
      @(posedge core_clk);
    while (wbAck !== 1'b1);
    rdq = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0);
    chk(rdq, e, s);
  endtask
  // each request flips the contact once, two cycles apart
  task automatic toggle(input logic [15:0] m, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      flipReq <= m;
      @(posedge core_clk);
      flipReq <= 16'h0;
    end
  endtask
  task automatic bit1(input logic b, e, input string s);
    chk({31'h0, b}, {31'h0, e}, s);
  endtask
  task automatic test_defaults;
    rd(ifsd_pkg::A_GDIAG, 32'hFFFF, "gdiag");
    rd(ifsd_pkg::A_WIN, 32'h2, "win");
    wb(1'b1, ifsd_pkg::A_WIN, 32'h65);
    rd(ifsd_pkg::A_WIN, 32'h2, "win ovr");
    rd(ifsd_pkg::A_CHCFG, 32'h14, "chcfg");
    rd(8'hFC, 32'h0, "unmapped");
    wb(1'b1, ifsd_pkg::A_CHSEL, 32'h4);
    wb(1'b1, ifsd_pkg::A_STYPE, 32'h3);
    wb(1'b1, ifsd_pkg::A_CHSEL, 32'h5);
    rd(ifsd_pkg::A_STYPE, 32'h3, "pair type");
    wb(1'b1, ifsd_pkg::A_CHSEL, 32'h6);
    rd(ifsd_pkg::A_STYPE, 32'h1, "other pair");
    $display("done defaults");
  endtask
  task automatic test_flutter;
    wb(1'b1, ifsd_pkg::A_CTRL, 32'h1);
    wb(1'b1, ifsd_pkg::A_IRQEN, 32'hFFFF_FFFF);
    wb(1'b1, ifsd_pkg::A_WIN, 32'h1);
    wb(1'b1, ifsd_pkg::A_CHSEL, 32'h0);
    wb(1'b1, ifsd_pkg::A_CHCFG, 32'h08);
    wb(1'b1, ifsd_pkg::A_FLEN, 32'h3);
    toggle(16'h1, 2);
    repeat (100) @(posedge core_clk);
    toggle(16'h1, 2);
    repeat (5) @(posedge core_clk);
    bit1(valueValid[0], 1'b1, "at limit");
    toggle(16'h1, 1);
    repeat (5) @(posedge core_clk);
    bit1(valueValid[0], 1'b0, "over limit");
    bit1(processImage[0], 1'b1, "image copy");
    bit1(chanErrLed[0], 1'b1, "led");
    rd(ifsd_pkg::A_DIAG, 32'h1, "diag in");
    rd(ifsd_pkg::A_IRQST, 32'h1, "irq in");
    bit1(irq, 1'b1, "irq level");
    wb(1'b1, ifsd_pkg::A_IRQCLR, 32'hFFFF_FFFF);
    bit1(irq, 1'b0, "irq cleared");
    repeat (60) @(posedge core_clk);
    toggle(16'h1, 1);
    repeat (80) @(posedge core_clk);
    bit1(valueValid[0], 1'b0, "quiet restart");
    repeat (100) @(posedge core_clk);
    bit1(valueValid[0], 1'b1, "cleared");
    bit1(chanErrLed[0], 1'b0, "led off");
    rd(ifsd_pkg::A_DIAG, 32'h0, "diag out");
    rd(ifsd_pkg::A_IRQST, 32'h1_0000, "irq out");
    wb(1'b1, ifsd_pkg::A_IRQEN, 32'h0);
    bit1(irq, 1'b0, "irq masked");
    wb(1'b1, ifsd_pkg::A_IRQCLR, 32'hFFFF_FFFF);
    wb(1'b1, ifsd_pkg::A_IRQEN, 32'hFFFF_FFFF);
    $display("done flutter");
  endtask
  task automatic test_nogroup;
    wb(1'b1, ifsd_pkg::A_GDIAG, 32'hFFFD);
    toggle(16'h2, 6);
    repeat (5) @(posedge core_clk);
    bit1(valueValid[1], 1'b0, "status kept");
    bit1(chanErrLed[1], 1'b0, "no led");
    rd(ifsd_pkg::A_DIAG, 32'h0, "no entry");
    bit1(irq, 1'b0, "no irq");
    repeat (200) @(posedge core_clk);
    bit1(valueValid[1], 1'b1, "recovered");
    $display("done nogroup");
  endtask
  task automatic test_stretch;
    wb(1'b1, ifsd_pkg::A_CHSEL, 32'h2);
    wb(1'b1, ifsd_pkg::A_CHCFG, 32'h09);
    wb(1'b1, ifsd_pkg::A_FLEN, 32'h7);
    toggle(16'h4, 4);
    repeat (10) @(posedge core_clk);
    bit1(processImage[2], 1'b1, "stretched");
    bit1(valueValid[2], 1'b1, "stretched monitor");
    repeat (100) @(posedge core_clk);
    bit1(processImage[2], 1'b0, "pulse end");
    $display("done stretch");
  endtask
  task automatic test_ident;
    logic [31:0] s;
    rd(ifsd_pkg::A_HWREV, 32'h1, "hw rev");
    wb(1'b0, ifsd_pkg::A_STATREV, 32'h0);
    s = rdq;
    wb(1'b1, ifsd_pkg::A_CTRL, 32'h1);
    rd(ifsd_pkg::A_STATREV, s + 32'h1, "stat rev");
    wb(1'b1, ifsd_pkg::A_ID_BASE, 32'h3130_2E32);
    wb(1'b1, 8'hCC, 32'h4142_4344);
    rd(ifsd_pkg::A_ID_BASE, 32'h3130_2E32, "date");
    rd(8'hCC, 32'h4142_4344, "desc end");
    wb(1'b1, 8'hCC, 32'h0000_0058, 4'h1);
    rd(8'hCC, 32'h4142_4358, "byte lane");
    wb(1'b1, ifsd_pkg::A_FWBUMP, 32'h1);
    wb(1'b1, ifsd_pkg::A_HWREV, 32'h0);
    rd(ifsd_pkg::A_FWREV, 32'h2, "fw bump");
    rd(ifsd_pkg::A_HWREV, 32'h2, "hw follows");
    $display("done ident");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    test_defaults();
    test_flutter();
    test_nogroup();
    test_stretch();
    test_ident();
    end_of_test();
  end
  // about 900 cycles expected; generous margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
endmodule // ifsd_core_tb
bind ifsd_core ifsd_core_chk #(.TICK_CYCLES(TICK_CYCLES)) chkI
  (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .sensorIn(sensorIn), .processImage(processImage),
   .valueValid(valueValid), .chanErrLed(chanErrLed), .irq(irq));
`default_nettype wire

// ---- ifsd_id_mem.sv ----
/*
  Small word memory for the identification text fields with byte writes
  and registered read data. Assumes index within ID_WORDS.
*/
`default_nettype none
module ifsd_id_mem
(
  input  wire logic        core_clk,
  input  wire logic        wrEn,
  input  wire logic [3:0]  wrSel,
  input  wire logic [4:0]  addr,
  input  wire logic [31:0] wrData,
  output var  logic [31:0] rdData
);
  logic [31:0] mem [ifsd_pkg::ID_WORDS];

  always_ff @(posedge core_clk)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (wrEn && wrSel[b])
        mem[addr][8*b +: 8] <= wrData[8*b +: 8];
    end
  end

  always_ff @(posedge core_clk)
  begin
    rdData <= mem[addr];
  end
endmodule // ifsd_id_mem
`default_nettype wire

// ---- ifsd_pkg.sv ----
/*
  Package for the sixteen-channel input conditioning block: register map,
  field layouts, reset values and timing constants.
  Assumes a 50 MHz core clock and a classic Wishbone register bus.
*/
`default_nettype none
package ifsd_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned NUM_CH        = 16;
  localparam int unsigned NUM_GRP       = 8;
  // time base: one tick every 0.5 s
  localparam int unsigned HALF_SEC_MS   = 500;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int unsigned QUIET_MULT    = 3;
  // window code: 0 = 0.5 s, 1..100 = seconds
  localparam logic [6:0]  WIN_MAX       = 7'h64;
  localparam logic [6:0]  WIN_RST       = 7'h02;
  localparam logic [4:0]  LIM_MIN       = 5'h02;
  localparam logic [4:0]  LIM_RST       = 5'h05;
  localparam logic [1:0]  STR_RST       = 2'h0;
  localparam logic [15:0] GDIAG_RST     = 16'hFFFF;
  localparam logic [2:0]  STYPE_RST     = 3'h1;
  // identity values, arbitrary
  localparam logic [31:0] HW_REV_RST    = 32'h0000_0001;
  localparam logic [31:0] FW_REV_RST    = 32'h0000_0001;
  localparam logic [31:0] SERIAL_RST    = 32'h0000_1234;
  localparam logic [31:0] MAKER_ID      = 32'h0000_00A5;
  localparam logic [31:0] DEVICE_ID     = 32'h0000_0C16;
  // register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_GDIAG   = 8'h04;
  localparam logic [7:0] A_FLEN    = 8'h08;
  localparam logic [7:0] A_WIN     = 8'h0C;
  localparam logic [7:0] A_STYPE   = 8'h10;
  localparam logic [7:0] A_CHSEL   = 8'h14;
  localparam logic [7:0] A_CHCFG   = 8'h18;
  localparam logic [7:0] A_IMAGE   = 8'h1C;
  localparam logic [7:0] A_VSTAT   = 8'h20;
  localparam logic [7:0] A_DIAG    = 8'h24;
  localparam logic [7:0] A_IRQST   = 8'h28;
  localparam logic [7:0] A_IRQCLR  = 8'h2C;
  localparam logic [7:0] A_IRQEN   = 8'h30;
  localparam logic [7:0] A_LED     = 8'h34;
  localparam logic [7:0] A_MAKER   = 8'h38;
  localparam logic [7:0] A_DEVID   = 8'h3C;
  localparam logic [7:0] A_SERIAL  = 8'h40;
  localparam logic [7:0] A_HWREV   = 8'h44;
  localparam logic [7:0] A_FWREV   = 8'h48;
  localparam logic [7:0] A_STATREV = 8'h4C;
  localparam logic [7:0] A_FWBUMP  = 8'h50;
  localparam logic [7:0] A_ID_BASE = 8'h80;
  // text store: 16 + 32 + 32 characters, 4 per word
  localparam int unsigned DATE_CH = 16;
  localparam int unsigned TAG_CH  = 32;
  localparam int unsigned DESC_CH = 32;
  localparam int unsigned ID_WORDS = (DATE_CH + TAG_CH + DESC_CH) / 4;
  // irq status bits per channel: [15:0] incoming, [31:16] outgoing
  typedef struct packed {
    logic [1:0] stretch;
    logic [4:0] limit;
    logic       flutEn;
  } ifsd_chcfg_s;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ifsd_wbreq_s;
endpackage : ifsd_pkg
`default_nettype wire

// ---- ifsd_sensor_model.sv ----
/*
  Field side of the input block: sixteen contacts that change state
  only when the bench asks. Assumes flipReq is driven after an edge.
*/
`default_nettype none
module ifsd_sensor_model
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] flipReq,
  output var  logic [15:0] sensorIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // a contact holds its level until told; no spontaneous bounce
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sensorIn <= 16'h0000;
    else
      sensorIn <= sensorIn ^ flipReq;
  end
endmodule // ifsd_sensor_model
`default_nettype wire

// ---- ifsd_stretch.sv ----
/*
  Per-channel pulse stretcher: a high pulse is held for at least the
  selected minimum; longer pulses pass unchanged. Assumes a 0.5 s tick.
*/
`default_nettype none
module ifsd_stretch
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  input  wire logic       din,
  output logic            dout
);
  logic [2:0] hold_r;
  logic       din_r;
  logic [2:0] minTicks;

  // 0 off, 1 = 0.5 s, 2 = 1 s, 3 = 2 s
  always_comb
  begin
    unique case (sel)
      2'h0: minTicks = 3'h0;
      2'h1: minTicks = 3'h1;
      2'h2: minTicks = 3'h2;
      2'h3: minTicks = 3'h4;
    endcase
  end

  // hold counts down the ticks left after the rising edge; tick granularity adds up
  // to one tick of extra stretch, never less than the minimum
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hold_r <= 3'h0;
      din_r  <= 1'b0;
    end
    else
    begin
      din_r <= din;
      if (din && !din_r)
        hold_r <= minTicks + 3'h1;
      else if (tick && hold_r != 3'h0)
        hold_r <= hold_r - 3'h1;
    end
  end

  assign dout = (sel == 2'h0) ? din : (din | (hold_r != 3'h0));
endmodule // ifsd_stretch
`default_nettype wire
